// ===== design/uart_irq_baud.sv
`timescale 1ns/1ps
`include "uart_irq_defines.svh"

module uart_irq_baud
    import uart_irq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [2:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    input wire logic [7:0] rx_data,
    input wire logic rx_ready,
    input wire logic [4:0] rx_count,
    input wire logic rx_push,
    input wire logic tx_buf_empty,
    input wire logic tx_idle,
    input wire logic overrun_flag,
    input wire logic parity_error_flag,
    input wire logic missing_stop_flag,
    input wire logic break_flag,
    input wire logic cts_b,
    input wire logic dsr_b,
    input wire logic ri_b,
    input wire logic dcd_b,
    input wire logic fast_rate_select,
    input wire logic turbo_rate_select,
    output logic rx_read,
    output logic tx_write,
    output logic [7:0] tx_data,
    output logic fifo_enable,
    output logic rx_fifo_reset,
    output logic tx_fifo_reset,
    output logic [7:0] line_ctrl,
    output logic dtr_b,
    output logic rts_b,
    output logic baud16_tick,
    output logic irq_out,
    output logic irq_oe_b
);

    // -------------------------------------------------------------
    // Bus decode
    // -------------------------------------------------------------
    logic div_access;
    logic wr_div_lo;
    logic wr_div_hi;
    logic wr_tx;
    logic rd_rx;
    logic rd_ident;
    logic rd_line;
    logic rd_hs;

    assign div_access = line_ctrl[`LC_DIV_ACCESS];
    assign wr_div_lo = ce && wr_en && addr == `OFS_DATA && div_access;
    assign wr_div_hi = ce && wr_en && addr == `OFS_ENABLE && div_access;
    assign wr_tx = ce && wr_en && addr == `OFS_DATA && !div_access;
    assign rd_rx = ce && rd_en && addr == `OFS_DATA && !div_access;
    assign rd_ident = ce && rd_en && addr == `OFS_IDENT;
    assign rd_line = ce && rd_en && addr == `OFS_LINE_STATUS;
    assign rd_hs = ce && rd_en && addr == `OFS_HS_STATUS;

    // -------------------------------------------------------------
    // Control registers
    // -------------------------------------------------------------
    logic [`IE_WIDTH-1:0] irq_en_q;
    logic [`MC_WIDTH-1:0] modem_ctrl_q;
    logic [1:0] trig_sel_q;
    logic [15:0] divisor_q;
    logic [7:0] scratch_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_en_q <= '0;
            modem_ctrl_q <= '0;
            trig_sel_q <= '0;
            fifo_enable <= 1'b0;
            line_ctrl <= `RST_BYTE;
            scratch_q <= `RST_BYTE;
        end else if (ce && wr_en) begin
            case (addr)
                `OFS_ENABLE: begin
                    if (!div_access) begin
                        irq_en_q <= wr_data[`IE_WIDTH-1:0];
                    end
                end
                `OFS_IDENT: begin
                    fifo_enable <= wr_data[`FC_FIFO_EN];
                    trig_sel_q <= wr_data[`FC_TRIG_HI:`FC_TRIG_LO];
                end
                `OFS_LINE_CTRL: line_ctrl <= wr_data;
                `OFS_MODEM_CTRL: modem_ctrl_q <= wr_data[`MC_WIDTH-1:0];
                `OFS_SCRATCH: scratch_q <= wr_data;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            divisor_q <= `RST_DIVISOR;
        end else if (wr_div_lo) begin
            divisor_q[7:0] <= wr_data;
        end else if (wr_div_hi) begin
            divisor_q[15:8] <= wr_data;
        end
    end

    // The FIFO reset bits clear themselves: they leave as one-cycle pulses.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_fifo_reset <= 1'b0;
            tx_fifo_reset <= 1'b0;
            tx_write <= 1'b0;
            tx_data <= `RST_BYTE;
            rx_read <= 1'b0;
        end else if (ce) begin
            rx_fifo_reset <= wr_en && addr == `OFS_IDENT && wr_data[`FC_RX_RESET];
            tx_fifo_reset <= wr_en && addr == `OFS_IDENT && wr_data[`FC_TX_RESET];
            tx_write <= wr_tx;
            rx_read <= rd_rx;
            if (wr_tx) begin
                tx_data <= wr_data;
            end
        end
    end

    // -------------------------------------------------------------
    // Modem pins
    // -------------------------------------------------------------
    logic [3:0] pin_meta_q;
    logic [3:0] pin_sync_q;
    logic [3:0] hs_level;
    logic [3:0] hs_prev_q;
    logic [3:0] hs_change_q;
    logic loopback;

    // Order of bits: cts, dsr, ri, dcd, all active high after inversion.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_meta_q <= '1;
            pin_sync_q <= '1;
        end else if (ce) begin
            pin_meta_q <= {dcd_b, ri_b, dsr_b, cts_b};
            pin_sync_q <= pin_meta_q;
        end
    end

    assign loopback = modem_ctrl_q[`MC_LOOPBACK];
    assign hs_level = loopback
        ? {modem_ctrl_q[`MC_IRQ_EN], modem_ctrl_q[`MC_LOOP_RI],
           modem_ctrl_q[`MC_DTR], modem_ctrl_q[`MC_RTS]}
        : ~pin_sync_q;

    // A change landing on the read cycle survives the clear.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hs_prev_q <= '0;
            hs_change_q <= '0;
        end else if (ce) begin
            hs_prev_q <= hs_level;
            for (int i = 0; i < 4; i++) begin
                // Ring reports only its trailing edge, the others any edge.
                if (i == 2 ? (hs_prev_q[i] && !hs_level[i])
                           : (hs_prev_q[i] != hs_level[i])) begin
                    hs_change_q[i] <= 1'b1;
                end else if (rd_hs) begin
                    hs_change_q[i] <= 1'b0;
                end
            end
        end
    end

    // Loopback parks the modem outputs in their inactive state.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dtr_b <= 1'b1;
            rts_b <= 1'b1;
        end else if (ce) begin
            dtr_b <= loopback || !modem_ctrl_q[`MC_DTR];
            rts_b <= loopback || !modem_ctrl_q[`MC_RTS];
        end
    end

    // -------------------------------------------------------------
    // Line status and transmit empty sources
    // -------------------------------------------------------------
    logic [3:0] line_err_q;
    logic [3:0] line_evt;
    logic tx_empty_prev_q;
    logic tx_empty_pend_q;
    irq_id_e cur_id;

    assign line_evt = {break_flag, missing_stop_flag, parity_error_flag, overrun_flag};

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            line_err_q <= '0;
        end else if (ce) begin
            line_err_q <= line_evt | (rd_line ? 4'h0 : line_err_q);
        end
    end

    logic tx_empty_rise;
    assign tx_empty_rise = tx_buf_empty && !tx_empty_prev_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_empty_prev_q <= 1'b0;
            tx_empty_pend_q <= 1'b0;
        end else if (ce) begin
            tx_empty_prev_q <= tx_buf_empty;
            if (tx_empty_rise) begin
                tx_empty_pend_q <= 1'b1;
            end else if (wr_tx || (rd_ident && cur_id == ID_TX_EMPTY)) begin
                tx_empty_pend_q <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------
    // Receive sources
    // -------------------------------------------------------------
    logic [4:0] trig_level;
    logic rx_level_hit;
    logic [`TIMEOUT_W-1:0] idle_cnt_q;
    logic rx_timeout;

    always_comb begin
        case (trig_sel_q)
            2'b00: trig_level = `TRIG_LVL0;
            2'b01: trig_level = `TRIG_LVL1;
            2'b10: trig_level = `TRIG_LVL2;
            default: trig_level = `TRIG_LVL3;
        endcase
    end

    assign rx_level_hit = fifo_enable ? (rx_count >= trig_level) : rx_ready;

    // A receive FIFO read or push restarts the idle count, so the interrupt waits
    // four whole character times of silence.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            idle_cnt_q <= '0;
        end else if (ce) begin
            if (!fifo_enable || rx_count == 5'h00 || rd_rx || rx_push) begin
                idle_cnt_q <= '0;
            end else if (baud16_tick && !rx_timeout) begin
                idle_cnt_q <= idle_cnt_q + 1'b1;
            end
        end
    end

    assign rx_timeout = idle_cnt_q == `TIMEOUT_W'(`TIMEOUT_TICKS);

    // -------------------------------------------------------------
    // Priority and identification
    // -------------------------------------------------------------
    logic [7:0] ident_byte;

    always_comb begin
        if (irq_en_q[`IE_LINE] && |line_err_q) begin
            cur_id = ID_LINE;
        end else if (irq_en_q[`IE_RX_READY] && fifo_enable && rx_timeout) begin
            cur_id = ID_RX_TIMEOUT;
        end else if (irq_en_q[`IE_RX_READY] && rx_level_hit) begin
            cur_id = ID_RX_READY;
        end else if (irq_en_q[`IE_TX_EMPTY] && tx_empty_pend_q) begin
            cur_id = ID_TX_EMPTY;
        end else if (irq_en_q[`IE_HANDSHAKE] && |hs_change_q) begin
            cur_id = ID_HANDSHAKE;
        end else begin
            cur_id = ID_NONE;
        end
    end

    assign ident_byte = {fifo_enable, fifo_enable, 2'b00, cur_id};

    // Open-drain style pin: enable low means the pin is driven.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_out <= 1'b0;
            irq_oe_b <= 1'b1;
        end else if (ce) begin
            irq_out <= cur_id != ID_NONE;
            irq_oe_b <= !modem_ctrl_q[`MC_IRQ_EN];
        end
    end

    // -------------------------------------------------------------
    // Read data
    // -------------------------------------------------------------
    logic [7:0] rd_mux;

    always_comb begin
        case (addr)
            `OFS_DATA: rd_mux = div_access ? divisor_q[7:0] : rx_data;
            `OFS_ENABLE: rd_mux = div_access ? divisor_q[15:8]
                                             : {4'h0, irq_en_q};
            `OFS_IDENT: rd_mux = ident_byte;
            `OFS_LINE_CTRL: rd_mux = line_ctrl;
            `OFS_MODEM_CTRL: rd_mux = {3'b000, modem_ctrl_q};
            `OFS_LINE_STATUS: rd_mux = {1'b0, tx_idle, tx_buf_empty,
                                        line_err_q, rx_ready};
            `OFS_HS_STATUS: rd_mux = {hs_level[3], hs_level[2], hs_level[1],
                                      hs_level[0], hs_change_q};
            default: rd_mux = scratch_q;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= `RST_BYTE;
        end else if (ce) begin
            rd_data <= rd_en ? rd_mux : `RST_BYTE;
        end
    end

    // -------------------------------------------------------------
    // Baud generator
    // -------------------------------------------------------------
    // The reference is clk itself. A modulo-13 accumulator makes the
    // 1.8461 MHz step; fast mode adds 8 per cycle for eight times that
    // rate, turbo adds 13 and so ticks on every reference edge.
    logic [3:0] step;
    logic [4:0] acc_sum;
    logic [3:0] acc_q;
    logic ref_tick;
    logic [15:0] div_cnt_q;

    assign step = turbo_rate_select ? `STEP_TURBO
                : fast_rate_select ? `STEP_FAST
                : `STEP_NORMAL;
    assign acc_sum = {1'b0, acc_q} + {1'b0, step};
    assign ref_tick = acc_sum >= {1'b0, `PRESCALE};

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            acc_q <= '0;
        end else if (ce) begin
            acc_q <= ref_tick ? 4'(acc_sum - {1'b0, `PRESCALE}) : acc_sum[3:0];
        end
    end

    // A divisor of zero is outside the valid range and holds the output.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt_q <= '0;
            baud16_tick <= 1'b0;
        end else if (ce) begin
            baud16_tick <= 1'b0;
            if (divisor_q == 16'h0000) begin
                div_cnt_q <= '0;
            end else if (ref_tick) begin
                if (div_cnt_q <= 16'h0001) begin
                    div_cnt_q <= divisor_q;
                    baud16_tick <= 1'b1;
                end else begin
                    div_cnt_q <= div_cnt_q - 1'b1;
                end
            end
        end
    end

endmodule

// ===== design/uart_irq_defines.svh
`ifndef UART_IRQ_DEFINES_SVH
`define UART_IRQ_DEFINES_SVH

// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define OFS_DATA 3'h0
`define OFS_ENABLE 3'h1
`define OFS_IDENT 3'h2
`define OFS_LINE_CTRL 3'h3
`define OFS_MODEM_CTRL 3'h4
`define OFS_LINE_STATUS 3'h5
`define OFS_HS_STATUS 3'h6
`define OFS_SCRATCH 3'h7

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define LC_DIV_ACCESS 7
`define FC_FIFO_EN 0
`define FC_RX_RESET 1
`define FC_TX_RESET 2
`define FC_TRIG_HI 7
`define FC_TRIG_LO 6
`define MC_DTR 0
`define MC_RTS 1
`define MC_LOOP_RI 2
`define MC_IRQ_EN 3
`define MC_LOOPBACK 4
`define IE_RX_READY 0
`define IE_TX_EMPTY 1
`define IE_LINE 2
`define IE_HANDSHAKE 3
`define IE_WIDTH 4
`define MC_WIDTH 5

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_DIVISOR 16'h0000

// -----------------------------------------------------------------
// Receive trigger levels in characters
// -----------------------------------------------------------------
`define TRIG_LVL0 5'h01
`define TRIG_LVL1 5'h04
`define TRIG_LVL2 5'h08
`define TRIG_LVL3 5'h0e

// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define REF_CLK_KHZ 24000
`define NORMAL_REF_HZ 1846100
`define PRESCALE 4'hd
`define STEP_NORMAL 4'h1
`define STEP_FAST 4'h8
`define STEP_TURBO 4'hd
`define OVERSAMPLE 16
`define CHAR_BITS 10
`define TIMEOUT_CHARS 4
`define TIMEOUT_TICKS (`TIMEOUT_CHARS * `CHAR_BITS * `OVERSAMPLE)
`define TIMEOUT_W 10

`endif

// ===== design/uart_irq_pkg.sv
package uart_irq_pkg;

    // Identification codes, bits 3..0 of the identification register.
    typedef enum logic [3:0] {
        ID_NONE = 4'b0001,
        ID_LINE = 4'b0110,
        ID_RX_READY = 4'b0100,
        ID_RX_TIMEOUT = 4'b1100,
        ID_TX_EMPTY = 4'b0010,
        ID_HANDSHAKE = 4'b0000
    } irq_id_e;

endpackage

// ===== tb/modem_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Modem handshake pins
// ----------------------------------------------------------------
// Pins idle high, as a released line with its pull-up would, so reset shows no change.
module modem_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [3:0] flip,
    output logic cts_b,
    output logic dsr_b,
    output logic ri_b,
    output logic dcd_b
);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            {dcd_b, ri_b, dsr_b, cts_b} <= 4'hf;
        end else begin
            {dcd_b, ri_b, dsr_b, cts_b} <= {dcd_b, ri_b, dsr_b, cts_b} ^ flip;
        end
    end
endmodule

// ===== tb/uart_irq_baud_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module uart_irq_baud_monitor (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [2:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rd_data,
    input wire logic fast_rate_select,
    input wire logic turbo_rate_select,
    input wire logic rx_read,
    input wire logic tx_write,
    input wire logic [7:0] tx_data,
    input wire logic fifo_enable,
    input wire logic [7:0] line_ctrl,
    input wire logic baud16_tick,
    input wire logic irq_out,
    input wire logic irq_oe_b
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_rd_ident;
        ce && rd_en && addr == 3'h2;
    endsequence
    sequence s_rd_data;
        ce && rd_en && addr == 3'h0 && !line_ctrl[7];
    endsequence
    sequence s_wr_data;
        ce && wr_en && addr == 3'h0 && !line_ctrl[7];
    endsequence

    property p_ident_fifo;
        s_rd_ident |=> rd_data[7:6] == {2{$past(fifo_enable)}};
    endproperty
    property p_ident_zero;
        s_rd_ident |=> rd_data[5:4] == 2'b00 && ($past(fifo_enable) || !rd_data[3]);
    endproperty
    property p_ident_timeout;
        s_rd_ident ##1 rd_data[3] |-> rd_data[2:0] == 3'b100;
    endproperty
    property p_ident_none;
        s_rd_ident ##1 rd_data[0] |-> rd_data[3:1] == 3'b000;
    endproperty
    property p_enable_hi;
        ce && rd_en && addr == 3'h1 && !line_ctrl[7] |=> rd_data[7:4] == 4'h0;
    endproperty
    property p_oe_on;
        ce && wr_en && addr == 3'h4 && wr_data[3] ##1 ce |=> !irq_oe_b;
    endproperty
    property p_oe_off;
        ce && wr_en && addr == 3'h4 && !wr_data[3] ##1 ce |=> irq_oe_b;
    endproperty
    property p_tx_write;
        s_wr_data |=> tx_write && tx_data == $past(wr_data);
    endproperty
    property p_rx_read;
        s_rd_data |=> rx_read;
    endproperty
    // Normal-mode reference ticks are 13 cycles apart, so no divisor can space ticks closer.
    property p_tick_normal;
        baud16_tick && !fast_rate_select && !turbo_rate_select
            && $past(!fast_rate_select && !turbo_rate_select)
            |=> (!baud16_tick || fast_rate_select || turbo_rate_select)[*8];
    endproperty
    property p_gate_off;
        ce && wr_en && addr == 3'h1 && !line_ctrl[7] && wr_data[3:0] == 4'h0
            |=> ##[0:2] !irq_out;
    endproperty

    a_ident_fifo: assert property (p_ident_fifo) else $error("ident top bits wrong");
    a_ident_zero: assert property (p_ident_zero) else $error("ident bits 5:3 wrong");
    a_ident_timeout: assert property (p_ident_timeout) else $error("bit 3 without 2");
    a_ident_none: assert property (p_ident_none) else $error("idle ident code wrong");
    a_enable_hi: assert property (p_enable_hi) else $error("enable high bits set");
    a_oe_on: assert property (p_oe_on) else $error("irq pin not driven");
    a_oe_off: assert property (p_oe_off) else $error("irq pin driven");
    a_tx_write: assert property (p_tx_write) else $error("tx write lost");
    a_rx_read: assert property (p_rx_read) else $error("rx read lost");
    a_tick_normal: assert property (p_tick_normal) else $error("tick too soon");
    a_gate_off: assert property (p_gate_off) else $error("irq with no enables");
endmodule

bind uart_irq_baud uart_irq_baud_monitor u_mon (.clk(clk), .rst_b(rst_b), .ce(ce),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .fast_rate_select(fast_rate_select), .turbo_rate_select(turbo_rate_select),
    .rx_read(rx_read), .tx_write(tx_write), .tx_data(tx_data), .fifo_enable(fifo_enable),
    .line_ctrl(line_ctrl), .baud16_tick(baud16_tick), .irq_out(irq_out),
    .irq_oe_b(irq_oe_b));

// ===== tb/uart_irq_baud_test.sv
`timescale 1ns/1ps
module uart_irq_baud_test
    import uart_irq_pkg::*;
;
    logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1, wr_en = 1'b0, rd_en = 1'b0, rd_seen = 1'b0;
    logic rx_ready = 1'b0, tx_buf_empty = 1'b0, fast_rate_select = 1'b0, turbo_rate_select = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wr_data = 8'h00, rx_data = 8'h00, d, rd_data;
    logic [4:0] rx_count = 5'h00;
    logic rx_push = 1'b0;
    logic [3:0] lerr = 4'h0, flip = 4'h0;
    logic cts_b, dsr_b, ri_b, dcd_b, baud16_tick, irq_out, irq_oe_b;
    logic [7:0] exp_q [$];
    int mismatches = 0, checks = 0, cnt;
    integer seed = 32'hbf10277e;
    // Fast, turbo, divisor, ticks expected in a 1560-cycle window.
    logic [33:0] bt [6] = '{{2'b00, 16'h000c, 16'h000a}, {2'b10, 16'h0004, 16'h00f0},
        {2'b10, 16'h0001, 16'h03c0}, {2'b01, 16'h0001, 16'h0618},
        {2'b11, 16'h0001, 16'h0618}, {2'b00, 16'h0001, 16'h0078}};

    uart_irq_baud uut (.clk(clk), .rst_b(rst_b), .ce(ce), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .rx_data(rx_data),
        .rx_ready(rx_ready), .rx_count(rx_count), .rx_push(rx_push),
        .tx_buf_empty(tx_buf_empty), .tx_idle(1'b0), .overrun_flag(lerr[0]),
        .parity_error_flag(lerr[1]), .missing_stop_flag(lerr[2]), .break_flag(lerr[3]),
        .cts_b(cts_b), .dsr_b(dsr_b), .ri_b(ri_b), .dcd_b(dcd_b),
        .fast_rate_select(fast_rate_select), .turbo_rate_select(turbo_rate_select),
        .rx_read(), .tx_write(), .tx_data(), .fifo_enable(), .rx_fifo_reset(),
        .tx_fifo_reset(), .line_ctrl(), .dtr_b(), .rts_b(), .baud16_tick(baud16_tick),
        .irq_out(irq_out), .irq_oe_b(irq_oe_b));
    modem_model u_modem (.clk(clk), .rst_b(rst_b), .flip(flip), .cts_b(cts_b),
        .dsr_b(dsr_b), .ri_b(ri_b), .dcd_b(dcd_b));

    initial begin
        forever #50 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // Bus tasks and result checking
    // ----------------------------------------------------------------
    function automatic logic [7:0] idv(input logic f, input irq_id_e c);
        return {f, f, 2'b00, c};
    endfunction
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Each access leaves one idle edge so a strobe is never set and cleared in one step.
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        addr <= a;
        wr_data <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] v);
        addr <= a;
        rd_en <= 1'b1;
        exp_q.push_back(v);
        @(posedge clk);
        rd_en <= 1'b0;
        @(posedge clk);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic pulse(input logic line, input logic [3:0] v);
        if (line) begin
            lerr <= v;
        end else begin
            flip <= v;
        end
        @(posedge clk);
        lerr <= 4'h0;
        flip <= 4'h0;
        idle(5);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        rd_seen <= rd_en & ce;
        if (rd_seen === 1'b1) begin
            check("rd_data", 16'(rd_data), 16'(exp_q.pop_front()));
        end
    end

    initial begin
        idle(40000);
        mismatches++;
        summarize();
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        idle(3);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(3'h2, idv(1'b0, ID_NONE));
        d = 8'($random(seed));
        wr(3'h7, d);
        ce <= 1'b0;
        wr(3'h7, ~d);
        ce <= 1'b1;
        rd(3'h7, d);
        wr(3'h1, 8'hf0);
        rd(3'h1, 8'h00);
        wr(3'h4, 8'h08);
        idle(1);
        check("irq_oe_b", 16'(irq_oe_b), 16'h0000);
        for (int i = 0; i < 4; i++) begin
            wr(3'h1, 8'h04);
            pulse(1'b1, 4'(1 << i));
            rd(3'h2, idv(1'b0, ID_LINE));
            check("irq_out", 16'(irq_out), 16'h0001);
            rd(3'h5, 8'(2 << i));
            rd(3'h2, idv(1'b0, ID_NONE));
        end
        wr(3'h1, 8'h00);
        pulse(1'b1, 4'h2);
        rd(3'h2, idv(1'b0, ID_NONE));
        check("irq_out", 16'(irq_out), 16'h0000);
        wr(3'h1, 8'h0f);
        rd(3'h2, idv(1'b0, ID_LINE));
        rd(3'h5, 8'h04);
        tx_buf_empty <= 1'b1;
        rx_ready <= 1'b1;
        rx_data <= 8'($random(seed));
        idle(3);
        rd(3'h2, idv(1'b0, ID_RX_READY));
        rd(3'h0, rx_data);
        rx_ready <= 1'b0;
        idle(2);
        rd(3'h2, idv(1'b0, ID_TX_EMPTY));
        rd(3'h2, idv(1'b0, ID_NONE));
        tx_buf_empty <= 1'b0;
        idle(2);
        tx_buf_empty <= 1'b1;
        idle(3);
        rd(3'h2, idv(1'b0, ID_TX_EMPTY));
        wr(3'h0, d);
        rd(3'h2, idv(1'b0, ID_NONE));
        for (int i = 0; i < 4; i++) begin
            pulse(1'b0, 4'(1 << i));
            if (i == 2) begin
                rd(3'h2, idv(1'b0, ID_NONE));
                pulse(1'b0, 4'h4);
            end
            rd(3'h2, idv(1'b0, ID_HANDSHAKE));
            rd(3'h6, {~dcd_b, ~ri_b, ~dsr_b, ~cts_b, 4'(1 << i)});
            rd(3'h2, idv(1'b0, ID_NONE));
        end
        foreach (bt[k]) begin
            {fast_rate_select, turbo_rate_select} <= bt[k][33:32];
            wr(3'h3, 8'h80);
            wr(3'h0, bt[k][23:16]);
            wr(3'h1, bt[k][31:24]);
            rd(3'h0, bt[k][23:16]);
            rd(3'h1, bt[k][31:24]);
            wr(3'h3, 8'h00);
            idle(200);
            cnt = 0;
            repeat (1560) begin
                @(posedge clk);
                if (baud16_tick === 1'b1) begin
                    cnt++;
                end
            end
            check("baud16_tick", 16'(cnt), bt[k][15:0]);
        end
        wr(3'h2, 8'hc1);
        rd(3'h2, idv(1'b1, ID_NONE));
        rx_count <= 5'h0e;
        idle(2);
        rd(3'h2, idv(1'b1, ID_RX_READY));
        rx_count <= 5'h01;
        rd(3'h0, rx_data);
        rd(3'h2, idv(1'b1, ID_NONE));
        idle(7600);
        rd(3'h2, idv(1'b1, ID_NONE));
        idle(800);
        rd(3'h2, idv(1'b1, ID_RX_TIMEOUT));
        rd(3'h0, rx_data);
        rd(3'h2, idv(1'b1, ID_NONE));
        idle(4200);
        rx_push <= 1'b1;
        @(posedge clk);
        rx_push <= 1'b0;
        idle(4200);
        rd(3'h2, idv(1'b1, ID_NONE));
        wr(3'h2, 8'h00);
        rd(3'h2, idv(1'b0, ID_NONE));
        wr(3'h4, 8'h00);
        idle(1);
        check("irq_oe_b", 16'(irq_oe_b), 16'h0001);
        summarize();
    end
endmodule
